/* rtl/acm_defines.svh */
// offsets, field positions and timing constants of the audio clock monitor
`ifndef ACM_DEFINES_SVH
`define ACM_DEFINES_SVH

`define ACM_ADDR_W 8
`define ACM_ADDR_RATIO_HI 8'h5C
`define ACM_ADDR_RATIO_LO 8'h5D
`define ACM_ADDR_STATUS 8'h5E
`define ACM_ADDR_FLAGS 8'h5F

`define ACM_RATIO_LO_BIT 7
`define ACM_FLAG_HALT_BIT 4
`define ACM_FLAG_MISSING_BIT 2
`define ACM_FLAG_RESYNC_BIT 1
`define ACM_FLAG_ERROR_BIT 0
`define ACM_RESET_BYTE 8'h00

`define ACM_SYS_HZ 100000000
`define ACM_SYS_PERIOD_NS 10
`define ACM_MCLK_TIMEOUT_NS 1000
`define ACM_SER_TIMEOUT_NS 20000
`define ACM_FRAME_TIMEOUT_NS 300000
`define ACM_RESYNC_NS 10000
`define ACM_RATE_TOL_PCT 2

`define ACM_LRCLK_LOW_MIN 5
`define ACM_SCLK_RATIO_MIN 32
`define ACM_SCLK_RATIO_MAX 256
`define ACM_NOPLL_MIN_RATIO 128
`define ACM_MCLK_RATIO_TOL 2

`define ACM_FS_8K 8000
`define ACM_FS_16K 16000
`define ACM_FS_32K 32000
`define ACM_FS_48K 48000
`define ACM_FS_88K 88200
`define ACM_FS_96K 96000
`define ACM_FS_176K 176400
`define ACM_FS_192K 192000
`define ACM_FS_384K 384000

`endif

/* rtl/acm_pkg.sv */
// types shared by the audio clock monitor files
package acm_pkg;

	typedef struct packed {
		logic [8:0] ratio;
		logic [8:0] low_len;
	} acm_meas_t;

	typedef struct packed {
		logic master_clock_absent;
		logic pll_unlocked;
		logic frame_and_bit_clocks_absent;
		logic autoset_combination_error;
		logic master_clock_invalid;
		logic bit_clock_invalid;
		logic sample_rate_invalid;
	} acm_status_t;

	typedef struct packed {
		logic latched_master_halt;
		logic serial_clocks_missing;
		logic resync_in_progress;
		logic latched_clock_error;
	} acm_flags_t;

	typedef enum logic [1:0] {
		ACM_SYNC_IDLE = 2'b00,
		ACM_SYNC_BUSY = 2'b01,
		ACM_SYNC_DONE = 2'b11
	} acm_sync_state_t;

endpackage : acm_pkg

/* rtl/acm_frame_meter.sv */
// bit-clock domain frame meter: bit clocks per frame and frame-clock low length
`timescale 1ns/1ps
`default_nettype none
module acm_frame_meter #(
	parameter int CNT_W = 9
) (
	input wire logic bclk_in,
	input wire logic rst_in,
	input wire logic lrclk_in,
	output acm_pkg::acm_meas_t meas_out,
	output logic frame_tgl_out
);
	import acm_pkg::*;

	logic rst_s1;
	logic rst_s2;
	logic lr_s1;
	logic lr_s2;
	logic lr_prev;
	logic [CNT_W-1:0] bit_cnt;
	logic [CNT_W-1:0] low_cnt;
	logic frame_start;

	if (CNT_W != 9) begin : bad_width
		$error("frame meter counter width must match the measurement struct");
	end

	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (&v) ? v : CNT_W'(v + 1'b1);
	endfunction : sat_inc

	// reset is caught here because the bit clock may run while the system resets
	always_ff @(posedge bclk_in) begin
		rst_s1 <= rst_in;
		rst_s2 <= rst_s1;
	end

	always_ff @(posedge bclk_in) begin
		lr_s1 <= lrclk_in;
		lr_s2 <= lr_s1;
		lr_prev <= lr_s2;
	end

	assign frame_start = lr_s2 & ~lr_prev;

	// R1 - count bits per frame
	always_ff @(posedge bclk_in) begin
		if (rst_s2) begin
			bit_cnt <= '0;
			low_cnt <= '0;
		end else if (frame_start) begin
			bit_cnt <= CNT_W'(1);
			low_cnt <= '0;
		end else begin
			bit_cnt <= sat_inc(bit_cnt);
			low_cnt <= lr_s2 ? low_cnt : sat_inc(low_cnt);
		end
	end

	// words stay stable for a whole frame, the toggle tells the system side to take them
	always_ff @(posedge bclk_in) begin
		if (rst_s2) begin
			meas_out <= '0;
			frame_tgl_out <= 1'b0;
		end else if (frame_start) begin
			meas_out.ratio <= bit_cnt;
			meas_out.low_len <= low_cnt;
			frame_tgl_out <= ~frame_tgl_out;
		end
	end

endmodule : acm_frame_meter
`default_nettype wire

/* rtl/acm_clock_monitor.sv */
// audio clock detector and clock status registers
`timescale 1ns/1ps
`default_nettype none
`include "acm_defines.svh"

// Summary of operation
// R1 - count bit clocks per frame; ratio high part at 0x5C, lowest bit at 0x5D bit 7; 0x5C holds ratio bits 7 to 1 only, bit 8 is not read out
// R2 - ratio measured with one bit clock per frame is unreliable
// R3 - status bit 6 high while master clock halted, low while toggling
// R4 - status bit 5 low only when PLL enabled and locked
// R5 - status bit 4 high only when frame and bit clocks both held low
// R6 - status bit 3 high when rate and master ratio pairing unusable for auto set
// R7 - status bit 2 high when master ratio undetectable or frame low phase five bits or less
// R8 - status bit 1 low only while bit ratio stable and within 32 to 256
// R9 - status bit 0 high when sampling rate cannot be detected
// R10 - ignoring errors deasserts the sampling-rate-invalid bit
// R11 - flag bit 4 latches master clock halt; cleared by reading flags
// R12 - flag bit 2 shows frame and bit clocks both missing
// R13 - flag bit 1 high while clock resynchronization runs
// R14 - flag bit 0 latches any clock error; cleared by reading flags
// R15 - an event in the clearing read cycle keeps its latched bit set
// R16 - live status bits follow the detectors every cycle
module acm_clock_monitor #(
	parameter int FRAME_TO_CYC = (`ACM_FRAME_TIMEOUT_NS + `ACM_SYS_PERIOD_NS - 1) / `ACM_SYS_PERIOD_NS,
	parameter int PERIOD_W = 16,
	parameter int MRATIO_W = 12
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic bclk_in,
	input wire logic lrclk_in,
	input wire logic audio_master_clk_in,
	input wire logic pll_enable_in,
	input wire logic pll_locked_in,
	input wire logic error_ignore_control_in,
	input wire logic [`ACM_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	output acm_pkg::acm_status_t status_out,
	output acm_pkg::acm_flags_t flags_out
);
	import acm_pkg::*;

	localparam int MCLK_TO_CYC = (`ACM_MCLK_TIMEOUT_NS + `ACM_SYS_PERIOD_NS - 1) / `ACM_SYS_PERIOD_NS;
	localparam int SER_TO_CYC = (`ACM_SER_TIMEOUT_NS + `ACM_SYS_PERIOD_NS - 1) / `ACM_SYS_PERIOD_NS;
	localparam int RESYNC_CYC = (`ACM_RESYNC_NS + `ACM_SYS_PERIOD_NS - 1) / `ACM_SYS_PERIOD_NS;
	localparam int NRATES = 6;
	localparam int FS_LO [NRATES] = '{`ACM_FS_8K, `ACM_FS_16K, `ACM_FS_32K,
		`ACM_FS_88K, `ACM_FS_176K, `ACM_FS_384K};
	localparam int FS_HI [NRATES] = '{`ACM_FS_8K, `ACM_FS_16K, `ACM_FS_48K,
		`ACM_FS_96K, `ACM_FS_192K, `ACM_FS_384K};
	localparam int NMR = 14;
	localparam int MRATIOS [NMR] = '{32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048, 3072};

	if (FRAME_TO_CYC < 2 || FRAME_TO_CYC >= (1 << PERIOD_W)) begin : bad_frame_to
		$error("frame timeout must fit the period counter");
	end
	if (MRATIO_W < 12) begin : bad_mratio
		$error("master ratio counter too narrow for the largest ratio");
	end

	// true when a frame length in system cycles falls in a detectable rate window
	function automatic logic rate_ok(input logic [PERIOD_W-1:0] p);
		int i;
		int lo;
		int hi;
		rate_ok = 1'b0;
		for (i = 0; i < NRATES; i++) begin
			lo = (`ACM_SYS_HZ / FS_HI[i]) * (100 - `ACM_RATE_TOL_PCT) / 100;
			hi = (`ACM_SYS_HZ / FS_LO[i]) * (100 + `ACM_RATE_TOL_PCT) / 100;
			if (int'(p) >= lo && int'(p) <= hi) begin
				rate_ok = 1'b1;
			end
		end
	endfunction : rate_ok

	// true when a master clock count per frame sits near an allowed ratio
	function automatic logic mratio_ok(input logic [MRATIO_W-1:0] c);
		int i;
		mratio_ok = 1'b0;
		for (i = 0; i < NMR; i++) begin
			if (int'(c) + `ACM_MCLK_RATIO_TOL >= MRATIOS[i] && int'(c) <= MRATIOS[i] + `ACM_MCLK_RATIO_TOL) begin
				mratio_ok = 1'b1;
			end
		end
	endfunction : mratio_ok

	acm_meas_t meas;
	logic frame_tgl;
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic mclk_prev;
	logic tgl_prev;
	logic s_mclk;
	logic s_bclk;
	logic s_lrclk;
	logic s_locked;
	logic s_tgl;
	logic frame_evt;
	logic mclk_edge;
	logic [7:0] mclk_idle;
	logic [11:0] ser_low;
	logic [PERIOD_W-1:0] period_cnt;
	logic [PERIOD_W-1:0] period_q;
	logic [MRATIO_W-1:0] mratio_cnt;
	logic [MRATIO_W-1:0] mratio_q;
	logic [8:0] ratio_q;
	logic [8:0] prev_ratio_q;
	logic [8:0] low_q;
	logic mclk_gone;
	logic ser_gone;
	logic frame_lost;
	acm_status_t next_status;
	logic clk_err;
	logic clk_err_prev;
	logic rd_flags;
	acm_sync_state_t sync_state;
	logic [9:0] resync_cnt;

	acm_frame_meter #(
		.CNT_W(9)
	) u_meter (
		.bclk_in(bclk_in),
		.rst_in(rst_in),
		.lrclk_in(lrclk_in),
		.meas_out(meas),
		.frame_tgl_out(frame_tgl)
	);

	// pins and the meter toggle come from other domains: two flops before use
	always_ff @(posedge mclk_in) begin
		pin_s1 <= {frame_tgl, pll_locked_in, lrclk_in, bclk_in, audio_master_clk_in};
		pin_s2 <= pin_s1;
	end

	assign {s_tgl, s_locked, s_lrclk, s_bclk, s_mclk} = pin_s2;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mclk_prev <= 1'b0;
			tgl_prev <= 1'b0;
		end else begin
			mclk_prev <= s_mclk;
			tgl_prev <= s_tgl;
		end
	end

	assign mclk_edge = s_mclk & ~mclk_prev;
	assign frame_evt = s_tgl ^ tgl_prev;

	// R3 - master clock idle timeout
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mclk_idle <= '0;
		end else if (mclk_edge) begin
			mclk_idle <= '0;
		end else if (int'(mclk_idle) < MCLK_TO_CYC) begin
			mclk_idle <= mclk_idle + 8'h01;
		end
	end

	assign mclk_gone = int'(mclk_idle) >= MCLK_TO_CYC;

	// R5 - both serial lines held low
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ser_low <= '0;
		end else if (s_bclk | s_lrclk) begin
			ser_low <= '0;
		end else if (int'(ser_low) < SER_TO_CYC) begin
			ser_low <= ser_low + 12'h001;
		end
	end

	assign ser_gone = int'(ser_low) >= SER_TO_CYC;

	// frame length in system cycles and master clock rising edges per frame
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			period_cnt <= '0;
			mratio_cnt <= '0;
			period_q <= '0;
			mratio_q <= '0;
		end else if (frame_evt) begin
			period_q <= period_cnt;
			mratio_q <= mratio_cnt;
			period_cnt <= PERIOD_W'(1);
			mratio_cnt <= MRATIO_W'(mclk_edge);
		end else begin
			if (int'(period_cnt) < FRAME_TO_CYC) begin
				period_cnt <= period_cnt + 1'b1;
			end
			if (mclk_edge && !(&mratio_cnt)) begin
				mratio_cnt <= mratio_cnt + 1'b1;
			end
		end
	end

	assign frame_lost = int'(period_cnt) >= FRAME_TO_CYC;

	// R1 - the meter word is stable while its toggle crosses, so take it here
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ratio_q <= '0;
			prev_ratio_q <= '0;
			low_q <= '0;
		end else if (frame_evt) begin
			ratio_q <= meas.ratio;
			prev_ratio_q <= ratio_q;
			low_q <= meas.low_len;
		end
	end

	always_comb begin
		next_status = '0;
		// R3 - master clock halt
		next_status.master_clock_absent = mclk_gone;
		// R4 - disabled counts as unlocked
		next_status.pll_unlocked = ~(pll_enable_in & s_locked);
		// R5 - both serial clocks absent
		next_status.frame_and_bit_clocks_absent = ser_gone;
		// R7 - master ratio and short low phase
		next_status.master_clock_invalid = mclk_gone | frame_lost | ~mratio_ok(mratio_q)
			| (int'(low_q) <= `ACM_LRCLK_LOW_MIN);
		// R8 - R2 - stable in-range bit ratio; one bit per frame falls below the range
		next_status.bit_clock_invalid = frame_lost | ser_gone | (ratio_q != prev_ratio_q)
			| (int'(ratio_q) < `ACM_SCLK_RATIO_MIN) | (int'(ratio_q) > `ACM_SCLK_RATIO_MAX);
		// R9 - R10 - undetectable rate, hidden while errors are ignored
		next_status.sample_rate_invalid = (frame_lost | ~rate_ok(period_q)) & ~error_ignore_control_in;
		// R6 - auto set pairing check
		next_status.autoset_combination_error = frame_lost | ~rate_ok(period_q)
			| next_status.master_clock_invalid
			| (~pll_enable_in & (int'(mratio_q) < `ACM_NOPLL_MIN_RATIO));
	end

	// R16 - live bits re-evaluated every cycle
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			status_out <= '0;
		end else begin
			status_out <= next_status;
		end
	end

	assign clk_err = mclk_gone | ser_gone | next_status.autoset_combination_error
		| next_status.master_clock_invalid | next_status.bit_clock_invalid | (frame_lost | ~rate_ok(period_q));
	assign rd_flags = reg_rd_in && (reg_addr_in == `ACM_ADDR_FLAGS);

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			clk_err_prev <= 1'b0;
		end else begin
			clk_err_prev <= clk_err;
		end
	end

	// R13 - resync runs for a fixed time once errors clear
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			sync_state <= ACM_SYNC_IDLE;
			resync_cnt <= '0;
		end else begin
			case (sync_state)
				ACM_SYNC_IDLE: begin
					if (clk_err_prev && !clk_err) begin
						sync_state <= ACM_SYNC_BUSY;
						resync_cnt <= 10'(RESYNC_CYC - 1);
					end
				end
				ACM_SYNC_BUSY: begin
					if (clk_err) begin
						sync_state <= ACM_SYNC_IDLE;
					end else if (resync_cnt == '0) begin
						sync_state <= ACM_SYNC_DONE;
					end else begin
						resync_cnt <= resync_cnt - 10'h001;
					end
				end
				ACM_SYNC_DONE: begin
					sync_state <= ACM_SYNC_IDLE;
				end
				default: begin
					sync_state <= ACM_SYNC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			flags_out <= '0;
		end else begin
			// R11 - R15 - halt latch, set beats the clearing read
			flags_out.latched_master_halt <= mclk_gone | (flags_out.latched_master_halt & ~rd_flags);
			// R14 - R15 - error latch, set beats the clearing read
			flags_out.latched_clock_error <= clk_err | (flags_out.latched_clock_error & ~rd_flags);
			// R12 - live serial clock absence
			flags_out.serial_clocks_missing <= ser_gone;
			// R13 - live resync indicator
			flags_out.resync_in_progress <= (sync_state == ACM_SYNC_BUSY);
		end
	end

	// R1 - register read port; reserved and unmapped bits read zero
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			reg_rdata_out <= `ACM_RESET_BYTE;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`ACM_ADDR_RATIO_HI: reg_rdata_out <= {1'b0, ratio_q[7:1]};
				`ACM_ADDR_RATIO_LO: reg_rdata_out <= {ratio_q[0], 7'h00};
				`ACM_ADDR_STATUS: reg_rdata_out <= {1'b0, status_out};
				`ACM_ADDR_FLAGS: reg_rdata_out <= {3'h0, flags_out.latched_master_halt, 1'b0,
					flags_out.serial_clocks_missing, flags_out.resync_in_progress,
					flags_out.latched_clock_error};
				default: reg_rdata_out <= `ACM_RESET_BYTE;
			endcase
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	sequence err_ends_s;
		clk_err ##1 !clk_err;
	endsequence

	sequence resync_holds_s;
		flags_out.resync_in_progress [*8];
	endsequence

	halt_latch_set_a: assert property (mclk_gone |=> flags_out.latched_master_halt) // R11
		else $error("halt not latched");
	halt_read_clear_a: assert property ((rd_flags && !mclk_gone) |=> !flags_out.latched_master_halt) // R11
		else $error("halt survived a clearing read");
	set_beats_clear_a: assert property ((rd_flags && clk_err) |=> flags_out.latched_clock_error) // R15
		else $error("error lost on clearing read");
	error_latch_set_a: assert property (clk_err |=> flags_out.latched_clock_error) // R14
		else $error("error not latched");
	error_latch_hold_a: assert property ((flags_out.latched_clock_error && !rd_flags) |=> flags_out.latched_clock_error) // R14
		else $error("error latch dropped without a read");
	pll_disabled_a: assert property (!pll_enable_in |=> status_out.pll_unlocked) // R4
		else $error("disabled pll shown locked");
	ignore_hides_rate_a: assert property (error_ignore_control_in |=> !status_out.sample_rate_invalid) // R10
		else $error("rate invalid shown while ignored");
	absent_pair_match_a: assert property (status_out.frame_and_bit_clocks_absent == flags_out.serial_clocks_missing) // R12
		else $error("serial absence bits disagree");
	resync_window_a: assert property (err_ends_s |=> (##1 resync_holds_s) or (##[0:8] clk_err)) // R13
		else $error("resync flag too short");
	bit_range_a: assert property ((int'(ratio_q) < 32 || int'(ratio_q) > 256) |=> status_out.bit_clock_invalid) // R8
		else $error("out of range bit ratio shown valid");
	halt_live_a: assert property ($fell(mclk_gone) |=> !status_out.master_clock_absent) // R16
		else $error("master absent held after clock returned");
	short_low_a: assert property ((int'(low_q) <= 5) |=> status_out.master_clock_invalid) // R7
		else $error("short frame low phase not flagged");

endmodule : acm_clock_monitor
`default_nettype wire

/* tb/acm_audio_source.sv */
// behavioural audio source driving master, bit and frame clocks
`timescale 1ns/1ps
`default_nettype none
module acm_audio_source (
	input wire logic run_in,
	input wire logic mclk_run_in,
	input wire logic [8:0] bits_in,
	input wire logic [8:0] low_in,
	output logic bclk_out,
	output logic lrclk_out,
	output logic amclk_out
);
	// stopped serial clocks sit low, the way an absent source looks
	initial begin
		bclk_out = 1'b0;
		lrclk_out = 1'b0;
		#3.3;
		forever begin
			if (run_in) begin
				for (int i = 0; i < bits_in; i++) begin
					lrclk_out = (i >= low_in);
					#7.5 bclk_out = 1'b1;
					#7.5 bclk_out = 1'b0;
				end
			end else begin
				lrclk_out = 1'b0;
				#7.5;
			end
		end
	end

	// 41 ns gives 64 master periods per 175-bit frame; a halt keeps the level
	initial begin
		amclk_out = 1'b0;
		#1.7;
		forever #20.5 if (mclk_run_in) amclk_out = ~amclk_out;
	end
endmodule : acm_audio_source
`default_nettype wire

/* tb/test_audio_clock_monitor_status.sv */
// self-checking bench for the audio clock monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_audio_clock_monitor_status;
	import acm_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic pll_en = 1'b1;
	logic pll_lock = 1'b1;
	logic ign = 1'b0;
	logic rd = 1'b0;
	logic run = 1'b1;
	logic mrun = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [8:0] bits = 9'h0AF;
	logic [8:0] low = 9'h057;
	logic [7:0] rdata;
	logic [7:0] d;
	wire logic bclk;
	wire logic lrclk;
	wire logic amclk;
	acm_status_t st;
	acm_flags_t fl;
	int n_errors = 0;
	int checks = 0;
	int tb_bits [4] = '{31, 32, 256, 257};
	logic tb_inv [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

	always #5 mclk_in = ~mclk_in;

	acm_audio_source u_acm_audio_source (.run_in(run), .mclk_run_in(mrun), .bits_in(bits),
		.low_in(low), .bclk_out(bclk), .lrclk_out(lrclk), .amclk_out(amclk));

	acm_clock_monitor #(.FRAME_TO_CYC(3000)) u_acm_clock_monitor (.mclk_in(mclk_in),
		.rst_in(rst_in), .bclk_in(bclk), .lrclk_in(lrclk), .audio_master_clk_in(amclk),
		.pll_enable_in(pll_en), .pll_locked_in(pll_lock), .error_ignore_control_in(ign),
		.reg_addr_in(addr), .reg_rd_in(rd), .reg_rdata_out(rdata), .status_out(st),
		.flags_out(fl));

	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : tick

	// data is valid at the edge after the strobe, seen at the next falling edge
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(negedge mclk_in);
		addr = a;
		rd = 1'b1;
		@(negedge mclk_in);
		rd = 1'b0;
		v = rdata;
	endtask : rd_reg

	task automatic src(input logic [8:0] b, input logic [8:0] l);
		bits = b;
		low = l;
		tick(3000);
	endtask : src

	task automatic summarize;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize

	initial begin
		#900us;
		n_errors++;
		summarize();
	end

	initial begin
		// meter needs a few bit clocks inside reset too
		tick(5);
		rst_in = 1'b0;
		src(9'd175, 9'd87);
		rd_reg(8'h5C, d);
		`CHK(d, 8'h57)
		rd_reg(8'h5D, d);
		`CHK(d, 8'h80)
		rd_reg(8'h5E, d);
		`CHK(d, 8'h00)
		rd_reg(8'h5F, d);
		rd_reg(8'h5F, d);
		`CHK(d, 8'h00)
		rd_reg(8'h60, d);
		`CHK(d, 8'h00)
		for (int i = 0; i < 4; i++) begin
			src(tb_bits[i][8:0], tb_bits[i][9:1]);
			rd_reg(8'h5E, d);
			`CHK(d[1], tb_inv[i])
			`CHK(st.bit_clock_invalid, tb_inv[i])
			rd_reg(8'h5C, d);
			`CHK(d, {1'b0, tb_bits[i][7:1]})
			rd_reg(8'h5D, d);
			`CHK(d, {tb_bits[i][0], 7'h00})
		end
		src(9'd16, 9'd8);
		rd_reg(8'h5E, d);
		`CHK(d[0], 1'b1)
		ign = 1'b1;
		tick(5);
		rd_reg(8'h5E, d);
		`CHK(d[0], 1'b0)
		ign = 1'b0;
		src(9'd175, 9'd5);
		rd_reg(8'h5E, d);
		`CHK(d[2], 1'b1)
		src(9'd175, 9'd6);
		rd_reg(8'h5E, d);
		`CHK(d[2], 1'b0)
		src(9'd175, 9'd87);
		pll_lock = 1'b0;
		tick(5);
		rd_reg(8'h5E, d);
		`CHK(d[5], 1'b1)
		pll_lock = 1'b1;
		pll_en = 1'b0;
		tick(5);
		rd_reg(8'h5E, d);
		`CHK(d[5], 1'b1)
		`CHK(d[3], 1'b1)
		pll_en = 1'b1;
		tick(5);
		rd_reg(8'h5E, d);
		`CHK(d, 8'h00)
		// resync runs for 1000 cycles once the errors have gone
		tick(300);
		rd_reg(8'h5F, d);
		`CHK(d, 8'h03)
		tick(1500);
		rd_reg(8'h5F, d);
		`CHK(d, 8'h00)
		mrun = 1'b0;
		tick(300);
		rd_reg(8'h5E, d);
		`CHK(d[6], 1'b1)
		rd_reg(8'h5F, d);
		`CHK(d[4], 1'b1)
		rd_reg(8'h5F, d);
		`CHK(d[4], 1'b1)
		mrun = 1'b1;
		tick(3000);
		rd_reg(8'h5E, d);
		`CHK(d[6], 1'b0)
		rd_reg(8'h5F, d);
		`CHK(d[4], 1'b1)
		rd_reg(8'h5F, d);
		`CHK(d[4], 1'b0)
		run = 1'b0;
		tick(2500);
		rd_reg(8'h5E, d);
		`CHK(d[4], 1'b1)
		rd_reg(8'h5F, d);
		`CHK(d[2], 1'b1)
		`CHK(fl.serial_clocks_missing, 1'b1)
		run = 1'b1;
		tick(3000);
		rd_reg(8'h5E, d);
		`CHK(d[4], 1'b0)
		rd_reg(8'h5F, d);
		`CHK(d[2], 1'b0)
		summarize();
	end
endmodule : test_audio_clock_monitor_status
`default_nettype wire
